/* include/vtp_pkg.sv */
/*
 * constants shared by the test pattern generator top and its testbench.
 * assumes a 20 mhz system clock and a 32-bit avalon-mm register bus.
 */
package vtp_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL  = 8'h64;
   localparam logic [7:0] IDX_CFG   = 8'h65;
   localparam logic [7:0] IDX_IADDR = 8'h66;
   localparam logic [7:0] IDX_IDATA = 8'h67;
   localparam logic [7:0] IDX_STAT  = 8'h68;
   // reset values
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [7:0] CFG_RST   = 8'h00;
   localparam logic [7:0] IADDR_RST = 8'h00;
   localparam logic [7:0] IND_RST   = 8'h00;
   // control register fields
   localparam int CTRL_EN  = 0;
   localparam int CTRL_SEL = 4;
   // configuration register fields
   localparam int CFG_AUTO    = 0;
   localparam int CFG_INV     = 1;
   localparam int CFG_TSEL    = 2;
   localparam int CFG_EXTCLK  = 3;
   localparam int CFG_REDUCED = 4;
   // status register fields
   localparam int STAT_OVF = 3;
   // indirectly mapped registers
   localparam logic [3:0] IND_FTIME  = 4'h0;
   localparam logic [3:0] IND_HTOT_L = 4'h1;
   localparam logic [3:0] IND_HTOT_H = 4'h2;
   localparam logic [3:0] IND_VTOT_L = 4'h3;
   localparam logic [3:0] IND_VTOT_H = 4'h4;
   localparam logic [3:0] IND_HACT_L = 4'h5;
   localparam logic [3:0] IND_HACT_H = 4'h6;
   localparam logic [3:0] IND_VACT_L = 4'h7;
   localparam logic [3:0] IND_VACT_H = 4'h8;
   localparam logic [3:0] IND_HSW    = 4'h9;
   localparam logic [3:0] IND_VSW    = 4'ha;
   localparam logic [3:0] IND_HBP    = 4'hb;
   localparam logic [3:0] IND_VBP    = 4'hc;
   localparam logic [3:0] IND_SYNC   = 4'hd;
   localparam logic [3:0] IND_PMASK  = 4'he;
   localparam int IND_COUNT = 15;
   // sync configuration fields (1 = active high)
   localparam int SYNC_HPOL = 0;
   localparam int SYNC_VPOL = 1;
   // structure defaults
   localparam int FIFO_DEPTH = 32;
   localparam int DIV_RATIO  = 2;
   localparam int LOW_BITS   = 2;
endpackage

/* rtl/vtp_fifo.sv */
/*
 * synchronous fifo for generated pixels, registered read data.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module vtp_fifo #(
   parameter int WIDTH = 27,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_reset_n,
   // fill side
   input  wire logic             i_valid,
   output logic                  o_ready,
   input  wire logic [WIDTH-1:0] i_data,
   // drain side
   output logic                  o_valid,
   input  wire logic             i_ready,
   output logic      [WIDTH-1:0] o_data
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wptr_q;
   logic [AW:0]      rptr_q;
   logic             ovalid_q;
   logic [WIDTH-1:0] odata_q;

   // pointer compare; extra msb tells full from empty
   wire empty = (wptr_q == rptr_q);
   wire full  = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
   wire push  = i_valid && !full;
   wire pop   = !empty && (!ovalid_q || i_ready);
   assign o_ready = !full;
   assign o_valid = ovalid_q;
   assign o_data  = odata_q;

   // storage, no reset needed on data
   always_ff @(posedge i_clock) begin
      if (push) mem_q[wptr_q[AW-1:0]] <= i_data;
      if (pop) odata_q <= mem_q[rptr_q[AW-1:0]];
   end

   // pointers and output stage
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         wptr_q   <= '0;
         rptr_q   <= '0;
         ovalid_q <= 1'b0;
      end else begin
         if (push) wptr_q <= wptr_q + 1'b1;
         if (pop) rptr_q <= rptr_q + 1'b1;
         if (pop) ovalid_q <= 1'b1;
         else if (i_ready) ovalid_q <= 1'b0;
      end
   end
endmodule // vtp_fifo

/* rtl/vtp_top.sv */
/*
 * video test pattern generator: register file, timing, patterns.
 * assumes avalon-mm master on i_clock, video pins asynchronous,
 * and a pixel sink with valid/ready handshake.
 */
// The Avalon-MM register port was left to the implementer.
// Behaviour
// - depth bit clear gives 24-bit, set gives 18-bit using six msbs.
// - internal timing: clock bit clear uses divided clock, set uses pixel clock.
// - in external timing mode the clock source bit is ignored.
// - timing bit clear: follow incoming pixel clock, de, hsync, vsync.
// - timing bit set: build timing from totals, actives, widths, porches, sync.
// - invert bit set inverts colour output, clear leaves it unchanged.
// - auto scroll clear keeps the selected pattern indefinitely.
// - auto scroll set steps to next enabled pattern every frame-time frames.
// - an 8-bit indirect address selects the indirectly mapped register.
// - writing indirect data stores the byte in the addressed register.
// - reading indirect data returns the addressed register's value.
// - patterns are produced only while the enable bit is set, default off.
`timescale 1ns/1ps
module vtp_top
   import vtp_pkg::*;
#(
   parameter int DIV   = vtp_pkg::DIV_RATIO,
   parameter int DEPTH = vtp_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_reset_n,
   // avalon-mm slave
   input  wire logic [9:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   // incoming video timing
   input  wire logic        i_pclk,
   input  wire logic        i_de,
   input  wire logic        i_hs,
   input  wire logic        i_vs,
   // generated pixel stream
   output logic             o_pix_valid,
   input  wire logic        i_pix_ready,
   output logic      [23:0] o_pix_rgb,
   output logic             o_pix_de,
   output logic             o_pix_hs,
   output logic             o_pix_vs
);
   import vtp_pkg::*;

   initial begin
      if (DIV < 2) $error("divider ratio must be at least 2");
   end

   // bus slave: one wait cycle, answer on the second edge
   logic        ack_q;
   logic [31:0] rdata_q;
   wire         req    = i_avs_read || i_avs_write;
   wire         accept = req && ack_q;
   wire  [7:0]  idx    = i_avs_address[9:2];
   wire         wr_ok  = accept && i_avs_write && i_avs_byteenable[0];
   wire  [7:0]  wbyte  = i_avs_writedata[7:0];
   assign o_avs_waitrequest = req && !ack_q;
   assign o_avs_readdata    = rdata_q;

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) ack_q <= 1'b0;
      else ack_q <= req && !ack_q;
   end

   // software registers
   logic [7:0] ctrl_q;
   logic [7:0] cfg_q;
   logic [7:0] iaddr_q;
   logic [7:0] ind_q [IND_COUNT];
   logic       ovf_q;

   wire wr_ctrl  = wr_ok && idx == IDX_CTRL;
   wire wr_cfg   = wr_ok && idx == IDX_CFG;
   wire wr_iaddr = wr_ok && idx == IDX_IADDR;
   wire wr_idata = wr_ok && idx == IDX_IDATA;
   wire wr_stat  = wr_ok && idx == IDX_STAT;
   wire iaddr_ok = iaddr_q < 8'(IND_COUNT);
   wire [3:0] islot = iaddr_q[3:0];

   // direct registers; address only moves on its own write
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         ctrl_q  <= CTRL_RST;
         cfg_q   <= CFG_RST;
         iaddr_q <= IADDR_RST;
      end else begin
         if (wr_ctrl) ctrl_q <= wbyte;
         if (wr_cfg) cfg_q <= {1'b0, wbyte[6:0]}; // bit 7 reserved
         if (wr_iaddr) iaddr_q <= wbyte;
      end
   end

   // indirect registers, written through the data window
   always_ff @(posedge i_clock) begin
      for (int k = 0; k < IND_COUNT; k++) begin
         if (!i_reset_n) ind_q[k] <= IND_RST;
         else if (wr_idata && iaddr_ok && islot == 4'(k)) ind_q[k] <= wbyte;
      end
   end

   // read mux; unmapped indices answer zero
   logic [2:0] pat_q;
   logic [7:0] rd_mux;
   wire  [7:0] ind_rd = iaddr_ok ? ind_q[islot] : 8'h00;
   wire  [7:0] stat   = {4'h0, ovf_q, pat_q};
   always_comb begin
      unique case (idx)
         IDX_CTRL:  rd_mux = ctrl_q;
         IDX_CFG:   rd_mux = cfg_q;
         IDX_IADDR: rd_mux = iaddr_q;
         IDX_IDATA: rd_mux = ind_rd;
         IDX_STAT:  rd_mux = stat;
         default:   rd_mux = 8'h00;
      endcase
   end

   // read data latched in the wait cycle, stands at the answer edge
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) rdata_q <= 32'h0000_0000;
      else if (i_avs_read && !ack_q) rdata_q <= {24'h00_0000, rd_mux};
   end

   // decoded controls
   wire       en      = ctrl_q[CTRL_EN];
   wire [2:0] sel     = ctrl_q[CTRL_SEL+2:CTRL_SEL];
   wire       auto    = cfg_q[CFG_AUTO];
   wire       inv     = cfg_q[CFG_INV];
   wire       tsel    = cfg_q[CFG_TSEL];
   wire       extclk  = cfg_q[CFG_EXTCLK];
   wire       reduced = cfg_q[CFG_REDUCED];
   wire [11:0] htot = {ind_q[IND_HTOT_H][3:0], ind_q[IND_HTOT_L]};
   wire [11:0] vtot = {ind_q[IND_VTOT_H][3:0], ind_q[IND_VTOT_L]};
   wire [11:0] hact = {ind_q[IND_HACT_H][3:0], ind_q[IND_HACT_L]};
   wire [11:0] vact = {ind_q[IND_VACT_H][3:0], ind_q[IND_VACT_L]};
   wire [11:0] hsw  = {4'h0, ind_q[IND_HSW]};
   wire [11:0] vsw  = {4'h0, ind_q[IND_VSW]};
   wire [11:0] hbeg = hsw + {4'h0, ind_q[IND_HBP]};
   wire [11:0] vbeg = vsw + {4'h0, ind_q[IND_VBP]};
   wire [7:0]  pmask = ind_q[IND_PMASK];

   // two-flop synchronisers for the video pins
   logic [3:0] vid_s1;
   logic [3:0] vid_s2;
   logic       pclk_s3;
   logic       vs_s3;
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         vid_s1  <= 4'h0;
         vid_s2  <= 4'h0;
         pclk_s3 <= 1'b0;
         vs_s3   <= 1'b0;
      end else begin
         vid_s1  <= {i_pclk, i_de, i_hs, i_vs};
         vid_s2  <= vid_s1;
         pclk_s3 <= vid_s2[3];
         vs_s3   <= vid_s2[0];
      end
   end
   wire ext_edge = vid_s2[3] && !pclk_s3;
   wire ext_de   = vid_s2[2];
   wire ext_hs   = vid_s2[1];
   wire ext_vs   = vid_s2[0];

   // internal divided clock as a one-cycle enable
   localparam int DW = $clog2(DIV);
   logic [DW-1:0] div_q;
   wire div_tick = div_q == DW'(DIV - 1);
   always_ff @(posedge i_clock) begin
      if (!i_reset_n || div_tick) div_q <= '0;
      else div_q <= div_q + 1'b1;
   end

   // pixel rate; clock bit only counts with internal timing
   wire int_src = extclk ? ext_edge : div_tick;
   wire pix_en  = tsel ? int_src : ext_edge;

   // internal timing counters, stalled by fifo back-pressure
   logic [11:0] h_q;
   logic [11:0] v_q;
   logic        fifo_ready;
   wire step   = pix_en && tsel && fifo_ready;
   wire h_last = h_q >= htot - 12'h001;
   wire v_last = v_q >= vtot - 12'h001;
   always_ff @(posedge i_clock) begin
      if (!i_reset_n || !tsel) begin
         h_q <= 12'h000;
         v_q <= 12'h000;
      end else if (step) begin
         h_q <= h_last ? 12'h000 : h_q + 12'h001;
         if (h_last) v_q <= v_last ? 12'h000 : v_q + 12'h001;
      end
   end

   // internal sync and active window, polarity per sync setting
   wire int_hs = (h_q < hsw) ~^ ind_q[IND_SYNC][SYNC_HPOL];
   wire int_vs = (v_q < vsw) ~^ ind_q[IND_SYNC][SYNC_VPOL];
   wire int_de = h_q >= hbeg && h_q < hbeg + hact && v_q >= vbeg && v_q < vbeg + vact;

   // timing in use for the current pixel
   wire cur_de = tsel ? int_de : ext_de;
   wire cur_hs = tsel ? int_hs : ext_hs;
   wire cur_vs = tsel ? int_vs : ext_vs;
   wire frame_tick = tsel ? (step && h_last && v_last) : (ext_vs && !vs_s3);

   // pixel position within the active area
   logic [11:0] x_q;
   logic [11:0] y_q;
   logic        de_prev_q;
   wire pix_take = pix_en && (!tsel || fifo_ready);
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         x_q       <= 12'h000;
         y_q       <= 12'h000;
         de_prev_q <= 1'b0;
      end else begin
         if (frame_tick) y_q <= 12'h000;
         else if (pix_take && de_prev_q && !cur_de) y_q <= y_q + 12'h001;
         if (pix_take) x_q <= cur_de ? x_q + 12'h001 : 12'h000;
         if (pix_take) de_prev_q <= cur_de;
      end
   end

   // next enabled pattern after the current one, wrapping
   function automatic logic [2:0] next_enabled(input logic [2:0] cur, input logic [7:0] mask);
      logic [2:0] res;
      logic [2:0] cand;
      res = cur;
      for (int k = 7; k >= 1; k--) begin
         cand = cur + 3'(k);
         if (mask[cand]) res = cand;
      end
      return res;
   endfunction

   // auto scroll frame counter
   logic [7:0] fcnt_q;
   wire [7:0] ftime     = (ind_q[IND_FTIME] == 8'h00) ? 8'h01 : ind_q[IND_FTIME];
   wire       scroll_go = frame_tick && auto && en && (fcnt_q + 8'h01 >= ftime);
   wire [2:0] pat_next  = next_enabled(pat_q, pmask);
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         pat_q  <= 3'h0;
         fcnt_q <= 8'h00;
      end else if (!auto) begin
         pat_q  <= sel;
         fcnt_q <= 8'h00;
      end else if (scroll_go) begin
         pat_q  <= pat_next;
         fcnt_q <= 8'h00;
      end else if (frame_tick && en) begin
         fcnt_q <= fcnt_q + 8'h01;
      end
   end

   // pattern colour per component
   logic [23:0] raw;
   wire  [7:0]  gx = x_q[7:0];
   wire  [7:0]  gy = y_q[7:0];
   wire  [7:0]  ck = (x_q[0] ^ y_q[0]) ? 8'hff : 8'h00;
   always_comb begin
      unique case (pat_q)
         3'h0: raw = 24'hff_ffff;
         3'h1: raw = 24'h00_0000;
         3'h2: raw = 24'hff_0000;
         3'h3: raw = 24'h00_ff00;
         3'h4: raw = 24'h00_00ff;
         3'h5: raw = {gx, gx, gx};
         3'h6: raw = {gy, gy, gy};
         3'h7: raw = {ck, ck, ck};
      endcase
   end

   // invert, then trim low bits so 18-bit mode keeps six msbs
   wire [7:0]  keep   = reduced ? 8'hfc : 8'hff;
   wire [23:0] inv_c  = inv ? ~raw : raw;
   wire [23:0] colour = cur_de ? (inv_c & {keep, keep, keep}) : 24'h00_0000;

   // push into fifo only while enabled
   wire        push      = pix_en && en;
   wire [26:0] push_data = {cur_de, cur_hs, cur_vs, colour};

   // sticky overflow in external mode; set wins over write-one clear
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) ovf_q <= 1'b0;
      else if (push && !fifo_ready && !tsel) ovf_q <= 1'b1; // internal timing stalls instead
      else if (wr_stat && wbyte[STAT_OVF]) ovf_q <= 1'b0;
   end

   // pixel buffer toward the serializer datapath
   logic [26:0] out_data;
   vtp_fifo #(.WIDTH(27), .DEPTH(DEPTH)) u_fifo (
      .i_clock  (i_clock),
      .i_reset_n(i_reset_n),
      .i_valid  (push),
      .o_ready  (fifo_ready),
      .i_data   (push_data),
      .o_valid  (o_pix_valid),
      .i_ready  (i_pix_ready),
      .o_data   (out_data)
   );
   assign o_pix_de  = out_data[26];
   assign o_pix_hs  = out_data[25];
   assign o_pix_vs  = out_data[24];
   assign o_pix_rgb = out_data[23:0];

   // checks
   sequence s_req_first;
      req && !ack_q;
   endsequence

   a_bus_wait_once: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      s_req_first |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
      else $error("bus answer not after one wait");

   a_ind_read_data: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      (accept && i_avs_read && idx == IDX_IDATA && iaddr_ok) |-> o_avs_readdata[7:0] == ind_q[islot])
      else $error("indirect read mismatch");

   a_ind_write_data: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      (wr_idata && iaddr_q == 8'(IND_FTIME)) |=> ind_q[IND_FTIME] == $past(wbyte))
      else $error("indirect write lost");

   a_iaddr_kept: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      (accept && idx == IDX_IDATA) |=> $stable(iaddr_q))
      else $error("indirect address moved");

   a_reduced_low: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      (push && reduced) |-> push_data[17:16] == 2'b00 && push_data[9:8] == 2'b00 && push_data[1:0] == 2'b00)
      else $error("18-bit mode low bits set");

   a_invert_white: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      (push && cur_de && pat_q == 3'h0 && !reduced) |-> push_data[23:0] == (inv ? 24'h00_0000 : 24'hff_ffff))
      else $error("invert wrong");

   a_disabled_quiet: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      !en |-> !push)
      else $error("pixel pushed while disabled");

   a_clock_source: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      pix_en == (tsel && !extclk ? div_tick : ext_edge))
      else $error("pixel rate from wrong source");

   a_ext_follow: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      (push && !tsel) |-> push_data[26:24] == {ext_de, ext_hs, ext_vs})
      else $error("external timing not followed");

   a_hold_pattern: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      (!auto && $stable(sel)) ##1 !auto |-> pat_q == $past(sel))
      else $error("pattern changed without scroll");

   a_scroll_step: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      scroll_go |=> pat_q == $past(pat_next) && fcnt_q == 8'h00)
      else $error("scroll did not advance");

   a_line_wrap: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      (step && h_last && tsel) ##1 tsel |-> h_q == 12'h000)
      else $error("line did not wrap");
endmodule // vtp_top

/* bench/vtp_sink.sv */
/*
 * pixel sink standing in for the serializer video datapath.
 * assumes the generator's valid/ready stream on the same clock.
 */
`timescale 1ns/1ps
module vtp_sink (
   // clock and reset
   input  wire logic i_clock,
   input  wire logic i_reset_n,
   // stall control from the bench
   input  wire logic i_slow,
   // stream handshake
   input  wire logic i_valid,
   output logic      o_ready
);
   // slow mode accepts about one cycle in four, so the fifo backs up
   always @(posedge i_clock) begin
      o_ready <= !i_reset_n ? 1'b0 : (i_slow ? ($urandom % 4 == 0) : 1'b1);
   end
endmodule // vtp_sink

/* bench/tb_video_test_pattern_generator.sv */
/*
 * self-checking bench for the test pattern generator top.
 * assumes vtp_pkg, vtp_top and vtp_fifo compiled before it.
 */
`timescale 1ns/1ps
module tb_video_test_pattern_generator;
   import vtp_pkg::*;
   logic        i_clock = 0, i_reset_n = 0, i_pclk = 0, i_de = 0, i_hs = 0, i_vs = 0;
   logic [9:0]  avs_address = '0;
   logic        avs_read = 0, avs_write = 0, pix_ready, slow = 0, pix_en = 0;
   logic [31:0] avs_writedata = '0;
   logic [3:0]  avs_byteenable = 4'h1;
   wire  [31:0] o_avs_readdata;
   wire         o_avs_waitrequest, o_pix_valid, o_pix_de, o_pix_hs, o_pix_vs;
   wire  [23:0] o_pix_rgb;
   logic [23:0] exp_rgb = '0;
   logic [7:0]  rdq[$];
   logic [7:0]  v[15];
   logic [4:0]  pdiv = '0;
   logic [3:0]  pos = '0;
   int          errors = 0, n_tests = 0, npix = 0, nall = 0, cyc = 0, n0, nhs = 0, n1;

   vtp_top dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_avs_address(avs_address),
      .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
      .i_avs_byteenable(avs_byteenable), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_pclk(i_pclk), .i_de(i_de), .i_hs(i_hs), .i_vs(i_vs),
      .o_pix_valid(o_pix_valid), .i_pix_ready(pix_ready), .o_pix_rgb(o_pix_rgb),
      .o_pix_de(o_pix_de), .o_pix_hs(o_pix_hs), .o_pix_vs(o_pix_vs));
   vtp_sink sink (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_slow(slow), .i_valid(o_pix_valid),
      .o_ready(pix_ready));

   initial begin
      forever #25 i_clock = ~i_clock;
   end

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one avalon access, held until waitrequest is seen low at an edge
   task automatic bus(input logic rd, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be,
                      input logic [7:0] e);
      @(posedge i_clock);
      avs_address    <= {idx, 2'b00};
      avs_read       <= rd;
      avs_write      <= !rd;
      avs_writedata  <= {24'h0, d};
      avs_byteenable <= be;
      if (rd) begin
         rdq.push_back(e);
      end
      do @(posedge i_clock); while (o_avs_waitrequest !== 1'b0);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b0, idx, d, 4'h1, 8'h00);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      bus(1'b1, idx, 8'h00, 4'h1, e);
   endtask

   // external video source: pixel clock of eight system clocks, 16-pixel lines
   always @(posedge i_clock) begin
      pdiv <= pdiv + 5'd1;
      if (pdiv[1:0] == 2'd3) begin
         i_pclk <= ~i_pclk;
         if (i_pclk) begin
            pos  <= pos + 4'd1;
            i_de <= (pos >= 4'd3 && pos < 4'd11);
            i_hs <= (pos < 4'd2);
            i_vs <= (pos == 4'd15);
         end
      end
   end

   // monitor: pops the oldest read note, checks active pixels
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
         chk("readdata", {24'h0, rdq.pop_front()}, o_avs_readdata);
      end
      if (o_pix_valid === 1'b1 && pix_ready === 1'b1) begin
         nall++;
         if (o_pix_hs === 1'b1) begin
            nhs++;
         end
         if (o_pix_de === 1'b1) begin
            npix++;
            if (pix_en) begin
               chk("pixel rgb", {8'h0, exp_rgb}, {8'h0, o_pix_rgb});
               chk("pixel syncs", 32'h0, {30'h0, o_pix_hs, o_pix_vs});
            end
         end
      end
      // timeout last, so nothing runs after the report
      if (cyc == 60000) begin
         errors++;
         final_report();
      end
   end

   // colour table: configuration, pattern select, expected active colour
   logic [7:0]  tcfg[8] = '{8'h04, 8'h06, 8'h14, 8'h16, 8'h04, 8'h0c, 8'h00, 8'h08};
   logic [2:0]  tsel[8] = '{3'd0, 3'd0, 3'd2, 3'd2, 3'd1, 3'd3, 3'd0, 3'd4};
   logic [23:0] texp[8] = '{24'hffffff, 24'h000000, 24'hfc0000, 24'h00fcfc,
                            24'h000000, 24'h00ff00, 24'hffffff, 24'h0000ff};
   // small frame: ftime 1, htot 10, vtot 6, hact 4, vact 2, widths and porches 1
   logic [7:0]  tind[15] = '{8'h01, 8'h0a, 8'h00, 8'h06, 8'h00, 8'h04, 8'h00, 8'h02, 8'h00,
                             8'h01, 8'h01, 8'h01, 8'h01, 8'h03, 8'h10};

   initial begin
      void'($urandom(32'h7ea5a0fd));
      repeat (3) @(posedge i_clock);
      i_reset_n <= 1'b1;
      // reset values and unmapped places
      rd(IDX_CTRL, CTRL_RST);
      rd(IDX_CFG, CFG_RST);
      rd(IDX_IADDR, IADDR_RST);
      rd(IDX_IDATA, IND_RST);
      rd(IDX_STAT, 8'h00);
      wr(8'h30, 8'h5a);
      rd(8'h30, 8'h00);
      $display("test reset values done");
      // indirect registers, random contents
      for (int i = 0; i < 15; i++) begin
         v[i] = 8'($urandom);
         wr(IDX_IADDR, 8'(i));
         wr(IDX_IDATA, v[i]);
      end
      for (int i = 14; i >= 0; i--) begin
         wr(IDX_IADDR, 8'(i));
         rd(IDX_IDATA, v[i]);
         rd(IDX_IADDR, 8'(i));
      end
      wr(IDX_IADDR, 8'h0f);
      wr(IDX_IDATA, 8'h77);
      rd(IDX_IDATA, 8'h00);
      bus(1'b0, IDX_IADDR, 8'h09, 4'h0, 8'h00);
      rd(IDX_IADDR, 8'h0f);
      $display("test indirect access done");
      // timing set-up, then every colour case, odd cases with stalls
      for (int i = 0; i < 15; i++) begin
         wr(IDX_IADDR, 8'(i));
         wr(IDX_IDATA, tind[i]);
      end
      for (int i = 0; i < 8; i++) begin
         wr(IDX_CFG, tcfg[i]);
         wr(IDX_CTRL, {1'b0, tsel[i], 4'h1});
         exp_rgb <= texp[i];
         slow    <= i[0];
         repeat (150) @(posedge i_clock);
         pix_en <= 1'b1;
         n0     = npix;
         n1     = nhs;
         repeat (500) @(posedge i_clock);
         pix_en <= 1'b0;
         chk("active pixels seen", 32'h1, {31'h0, npix > n0});
         chk("hsync pixels seen", 32'h1, {31'h0, nhs > n1});
      end
      $display("test colours done");
      // disabled generator sends nothing
      slow <= 1'b0;
      wr(IDX_CTRL, 8'h00);
      repeat (100) @(posedge i_clock);
      n0 = nall;
      repeat (400) @(posedge i_clock);
      chk("pixels while disabled", n0, nall);
      $display("test disable done");
      // scroll: only pattern 4 enabled in the mask
      wr(IDX_CFG, 8'h04);
      wr(IDX_CTRL, 8'h21);
      wr(IDX_STAT, 8'h08);
      repeat (400) @(posedge i_clock);
      rd(IDX_STAT, 8'h02);
      wr(IDX_CFG, 8'h05);
      repeat (400) @(posedge i_clock);
      rd(IDX_STAT, 8'h04);
      $display("test scroll done");
      repeat (5) @(posedge i_clock);
      final_report();
   end
endmodule // tb_video_test_pattern_generator
